// file: inc/sadc_params.svh
// What this block does
// - A four-way input selector feeds an 8-bit successive approximation core.
// - Channel field writes take effect only while busy and done are both 0.
// - Writing start with enable already 1 begins conversion; busy stays up, done sets, then busy clears.
// - Start requests while busy or done is 1 are ignored.
// - Done raises the interrupt only with global, local enable and top priority.
// - Result is loaded at completion and held until the next conversion completes.
// - A start write may change channel; a done-clearing write may not.
// - The enable bit cannot be cleared while busy or done is 1.
// - Clock select: 0 CPU clock, 1 RC clock; writable only when idle.
// - At completion done and busy both read 1 for exactly one cycle.
// - The ideal code is the input times 255 over the supply span, rounded.
// - Control register at C0h, resets to 00H, fields at bits 7, 4, 3, 2, 1..0.
// - On the CPU clock a conversion takes 31 machine cycles.
// - On the RC clock a conversion takes 3 cycles plus 109 RC clocks.
// - Power-down on the CPU clock aborts conversion without a done flag.
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_CTRL_ADDR 8'hC0
`define SADC_RES_ADDR 8'hC4
`define SADC_CTRL_RESET 8'h00
`define SADC_BIT_EN 7
`define SADC_BIT_DONE 4
`define SADC_BIT_START 3
`define SADC_BIT_RC 2
`define SADC_RES_VALID 8
`define SADC_CPU_CYCLES 31
`define SADC_CPU_STEPS 5'h1E
`define SADC_RC_TICKS 7'h6C
`define SADC_SYNC_CYCLES 2'h3
`define SADC_SAR_STEPS 7'h08
`define SADC_SETTLE_US 10
`define SADC_CLK_MHZ 100
`define SADC_SETTLE_CYC (`SADC_SETTLE_US * `SADC_CLK_MHZ)
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2
`endif

// file: inc/sadc_pkg.sv
package sadc_pkg;
	typedef struct packed {
		logic enable;
		logic [1:0] reserved;
		logic done;
		logic busy;
		logic rc_sel;
		logic [1:0] chan;
	} sadc_ctrl_s;
	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_SYNC,
		SADC_CONV,
		SADC_TAIL
	} sadc_state_e;
endpackage

// file: hdl/sadc_ctrl.sv
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_ctrl
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Digitised analog inputs, one code per channel
	input wire logic [7:0] analog_input_0,
	input wire logic [7:0] analog_input_1,
	input wire logic [7:0] analog_input_2,
	input wire logic [7:0] analog_input_3,
	// Conversion clock and power pins
	input wire logic rc_osc_clk,
	input wire logic power_down,
	// Interrupt controller side
	input wire logic global_irq_enable,
	input wire logic converter_irq_enable,
	input wire logic irq_top_priority,
	output logic conversion_irq,
	// Analog front end
	output logic [1:0] input_select
);
	// ======================================================
	// Input synchronisers
	logic [7:0] in_s1_reg [4];
	logic [7:0] in_s2_reg [4];
	logic [7:0] in_pins [4];
	logic [2:0] rc_s_reg;
	logic [1:0] pd_s_reg;
	assign in_pins[0] = analog_input_0;
	assign in_pins[1] = analog_input_1;
	assign in_pins[2] = analog_input_2;
	assign in_pins[3] = analog_input_3;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				in_s1_reg[gi] <= in_pins[gi];
				in_s2_reg[gi] <= in_s1_reg[gi];
			end
		end
	endgenerate
	always_ff @(posedge aclk)
	begin
		rc_s_reg <= {rc_s_reg[1:0], rc_osc_clk};
		pd_s_reg <= {pd_s_reg[0], power_down};
	end
	// The RC clock is far slower than aclk, so its rising edges become ticks.
	wire rc_tick = rc_s_reg[1] & ~rc_s_reg[2];
	wire pd_sync = pd_s_reg[1];

	// ======================================================
	// AXI4-Lite slave
	logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
	logic awready_reg, wready_reg, arready_reg;
	logic [7:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	wire aw_take = s_axi_awvalid & awready_reg;
	wire w_take = s_axi_wvalid & wready_reg;
	wire ar_take = s_axi_arvalid & arready_reg;
	wire wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire aw_full_next = (aw_full_reg | aw_take) & ~wr_fire;
	wire w_full_next = (w_full_reg | w_take) & ~wr_fire;
	wire bvalid_next = wr_fire | (bvalid_reg & ~s_axi_bready);
	wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
	wire wr_ctrl = awaddr_reg == `SADC_CTRL_ADDR;
	wire wr_res = awaddr_reg == `SADC_RES_ADDR;
	wire rd_ctrl = s_axi_araddr == `SADC_CTRL_ADDR;
	wire rd_res = s_axi_araddr == `SADC_RES_ADDR;
	wire sw = wr_fire & wr_ctrl & wstrb0_reg;
	wire [7:0] wd = wdata_reg;

	// ======================================================
	// Control register and conversion engine
	sadc_pkg::sadc_state_e state_reg, state_next;
	sadc_pkg::sadc_ctrl_s ctrl;
	logic enable_reg, done_reg, rc_sel_reg;
	logic [1:0] chan_reg;
	logic [6:0] cnt_reg;
	logic [7:0] sar_reg, mask_reg, result_reg;
	logic result_valid_reg, irq_reg, sel_reg;
	wire busy = state_reg != sadc_pkg::SADC_IDLE;
	wire unlocked = ~busy & ~done_reg;
	wire start_req = sw & wd[`SADC_BIT_START] & unlocked & enable_reg;
	wire abort = pd_sync & ~rc_sel_reg & busy
		& (state_reg != sadc_pkg::SADC_TAIL);
	wire step = (state_reg == sadc_pkg::SADC_CONV) & (~rc_sel_reg | rc_tick);
	wire [6:0] last = rc_sel_reg ? `SADC_RC_TICKS + 7'h01
		: {2'h0, `SADC_CPU_STEPS};
	wire done_set = step & (cnt_reg == last - 7'h01) & ~abort;
	wire [7:0] sample = in_s2_reg[chan_reg];
	wire [7:0] trial = sar_reg | mask_reg;
	// A bit is kept while the trial code stays at or below the input,
	// which yields the nearest-integer code of the ideal transfer.
	wire sar_keep = trial <= sample;
	wire sar_step = step & (cnt_reg < `SADC_SAR_STEPS);
	wire enable_next = sw ? (wd[`SADC_BIT_EN] | (enable_reg & ~unlocked))
		: enable_reg;
	wire clear_req = sw & ~wd[`SADC_BIT_DONE];
	// Hardware set wins over a software clear in the same cycle.
	wire done_next = done_set | (done_reg & ~clear_req);
	wire [1:0] chan_next = (sw & unlocked) ? wd[1:0] : chan_reg;
	wire rc_sel_next = (sw & unlocked) ? wd[`SADC_BIT_RC] : rc_sel_reg;
	wire irq_next = done_reg & global_irq_enable & converter_irq_enable
		& irq_top_priority;
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			sadc_pkg::SADC_IDLE:
			begin
				if (start_req)
					state_next = wd[`SADC_BIT_RC] ? sadc_pkg::SADC_SYNC
						: sadc_pkg::SADC_CONV;
			end
			sadc_pkg::SADC_SYNC:
			begin
				if (cnt_reg[1:0] == `SADC_SYNC_CYCLES - 2'h1)
					state_next = sadc_pkg::SADC_CONV;
			end
			sadc_pkg::SADC_CONV:
			begin
				if (abort)
					state_next = sadc_pkg::SADC_IDLE;
				else if (done_set)
					state_next = sadc_pkg::SADC_TAIL;
			end
			// Busy and done overlap for this one cycle only.
			sadc_pkg::SADC_TAIL: state_next = sadc_pkg::SADC_IDLE;
			default: state_next = sadc_pkg::SADC_IDLE;
		endcase
		if (abort)
			state_next = sadc_pkg::SADC_IDLE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= sadc_pkg::SADC_IDLE;
			enable_reg <= 1'b0;
			done_reg <= 1'b0;
			rc_sel_reg <= 1'b0;
			chan_reg <= 2'h0;
			irq_reg <= 1'b0;
			sel_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			enable_reg <= enable_next;
			done_reg <= done_next;
			rc_sel_reg <= rc_sel_next;
			chan_reg <= chan_next;
			irq_reg <= irq_next;
			sel_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || start_req || state_next != state_reg)
			cnt_reg <= 7'h00;
		else if (step || state_reg == sadc_pkg::SADC_SYNC)
			cnt_reg <= cnt_reg + 7'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || start_req)
		begin
			sar_reg <= 8'h00;
			mask_reg <= 8'h80;
		end
		else if (sar_step)
		begin
			sar_reg <= sar_keep ? trial : sar_reg;
			mask_reg <= mask_reg >> 1;
		end
	end

	// Writes to the result address are acknowledged and dropped.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			result_reg <= 8'h00;
			result_valid_reg <= 1'b0;
		end
		else if (done_set)
		begin
			result_reg <= sar_reg;
			result_valid_reg <= 1'b1;
		end
		else if (start_req || abort)
			result_valid_reg <= 1'b0;
	end

	// Reserved bits always read 0 whatever software writes.
	assign ctrl = '{enable: enable_reg, reserved: 2'h0, done: done_reg,
		busy: busy, rc_sel: rc_sel_reg, chan: chan_reg};
	wire [31:0] rd_word = rd_ctrl ? {24'h0, ctrl}
		: {23'h0, result_valid_reg, result_reg};
	wire rd_ok = rd_ctrl | rd_res;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
		end
		else
		begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			bvalid_reg <= bvalid_next;
			rvalid_reg <= rvalid_next;
			awready_reg <= ~aw_full_next & ~bvalid_next;
			wready_reg <= ~w_full_next & ~bvalid_next;
			arready_reg <= ~rvalid_next;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bresp_reg <= `SADC_RESP_OKAY;
			rresp_reg <= `SADC_RESP_OKAY;
			rdata_reg <= 32'h0;
		end
		else
		begin
			if (aw_take)
				awaddr_reg <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
				bresp_reg <= (wr_ctrl | wr_res) ? `SADC_RESP_OKAY
					: `SADC_RESP_SLVERR;
			if (ar_take)
			begin
				rdata_reg <= rd_ok ? rd_word : 32'h0;
				rresp_reg <= rd_ok ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign conversion_irq = irq_reg;
	assign input_select = chan_reg;

	// ======================================================
	// Checks
	logic [7:0] busy_cnt_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || start_req)
			busy_cnt_reg <= 8'h00;
		else if (busy)
			busy_cnt_reg <= busy_cnt_reg + 8'h01;
	end
	sequence overlap_s;
		done_reg && busy;
	endsequence
	sequence only_done_s;
		done_reg && !busy;
	endsequence
	start_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start_req |=> busy && !done_reg)
		else $error("start did not raise busy");
	start_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done_reg && !busy && sw) |=> !busy)
		else $error("start accepted while done set");
	tail_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(done_reg) |-> overlap_s ##1 only_done_s)
		else $error("busy and done overlap is not one cycle");
	cpu_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(busy) && done_reg && !rc_sel_reg)
		|-> busy_cnt_reg == `SADC_CPU_CYCLES)
		else $error("CPU clocked conversion length wrong");
	chan_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!unlocked |=> $stable(chan_reg) && $stable(rc_sel_reg))
		else $error("channel or clock select changed while locked");
	enable_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(enable_reg && !unlocked) |=> enable_reg)
		else $error("enable cleared while busy or done");
	result_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!done_set |=> $stable(result_reg))
		else $error("result changed outside completion");
	irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 conversion_irq == $past(irq_next))
		else $error("interrupt not gated by enables");
	done_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done_reg && !clear_req) |=> done_reg)
		else $error("done flag dropped without software clear");
	abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
		abort |=> !busy && $stable(done_reg))
		else $error("power-down did not abort conversion");
endmodule

// file: verification/sar_adc_control_tb.sv
`timescale 1ns/1ps
`include "sadc_params.svh"
module sar_adc_control_tb;
	// ==========================================================
	// Signals
	logic aclk;
	logic aresetn;
	logic [7:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [7:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	logic [7:0] ain [4];
	logic rc_osc_clk;
	logic [2:0] rc_div;
	logic power_down;
	logic [2:0] irq_en;
	logic conversion_irq;
	logic [1:0] input_select;
	int failures;
	int n_checks;
	int cyc;
	int t0;
	logic [31:0] rd_data;
	// ==========================================================
	// Device
	sadc_ctrl u_dut
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.analog_input_0(ain[0]), .analog_input_1(ain[1]),
		.analog_input_2(ain[2]), .analog_input_3(ain[3]),
		.rc_osc_clk(rc_osc_clk), .power_down(power_down),
		.global_irq_enable(irq_en[0]), .converter_irq_enable(irq_en[1]),
		.irq_top_priority(irq_en[2]), .conversion_irq(conversion_irq),
		.input_select(input_select)
	);
	// ==========================================================
	// Clocks and watchdog
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// The RC oscillator runs free at one eighth of aclk, slow enough for
	// the two-flop synchroniser to see every edge.
	always @(posedge aclk)
	begin
		rc_div <= rc_div + 3'h1;
		rc_osc_clk <= rc_div[2];
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			failures++;
			close_out();
		end
	end
	// ==========================================================
	// Tasks
	task automatic close_out();
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, hi, n);
		n_checks++;
		if (n < lo || n > hi)
		begin
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, n);
			failures++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_d;
		logic w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_d && w_d))
		begin
			@(posedge aclk);
			if (!aw_d && s_axi_awready)
			begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready)
			begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, (a == `SADC_CTRL_ADDR || a == `SADC_RES_ADDR) ?
			`SADC_RESP_OKAY : `SADC_RESP_SLVERR}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid)
			@(posedge aclk);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk("rresp", {30'h0, (a == `SADC_CTRL_ADDR || a == `SADC_RES_ADDR) ?
			`SADC_RESP_OKAY : `SADC_RESP_SLVERR}, {30'h0, s_axi_rresp});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk("read data", e, d);
	endtask
	task automatic wait_irq();
		while (!conversion_irq)
			@(posedge aclk);
	endtask
	// ==========================================================
	// Sequence
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		ain = '{8'h3C, 8'hA5, 8'hFF, 8'h00};
		{rc_div, rc_osc_clk, power_down} = '0;
		irq_en = 3'h7;
		{failures, n_checks, cyc} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0000);
		rd_chk(`SADC_RES_ADDR, 32'h0000_0000);
		rd_chk(8'h10, 32'h0000_0000);
		wr(8'h10, 32'h0000_0080);
		s_axi_wstrb <= 4'h0;
		wr(`SADC_CTRL_ADDR, 32'h0000_0080);
		s_axi_wstrb <= 4'hF;
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0000);
		wr(`SADC_CTRL_ADDR, 32'h0000_00E0);
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0080);
		repeat (`SADC_SETTLE_CYC) @(posedge aclk);
		for (int ch = 0; ch < 4; ch++)
		begin
			wr(`SADC_CTRL_ADDR, 32'h88 | ch);
			t0 = cyc;
			chk("input_select", ch, {30'h0, input_select});
			wr(`SADC_CTRL_ADDR, 32'h88 | (ch ^ 1));
			rd_chk(`SADC_CTRL_ADDR, 32'h88 | ch);
			wait_irq();
			// The irq output is registered, so it trails done by one cycle.
			chk_rng("cpu cycles", `SADC_CPU_CYCLES, `SADC_CPU_CYCLES + 2,
				cyc - t0);
			rd_chk(`SADC_CTRL_ADDR, 32'h90 | ch);
			rd_chk(`SADC_RES_ADDR, 32'h100 | ain[ch]);
			for (int i = 0; i < 3; i++)
			begin
				irq_en[i] <= 1'b0;
				repeat (3) @(posedge aclk);
				chk("irq masked", 32'h0, {31'h0, conversion_irq});
				irq_en[i] <= 1'b1;
				repeat (3) @(posedge aclk);
				chk("irq raised", 32'h1, {31'h0, conversion_irq});
			end
			wr(`SADC_CTRL_ADDR, 32'h98 | (ch ^ 2));
			rd_chk(`SADC_CTRL_ADDR, 32'h90 | ch);
			wr(`SADC_RES_ADDR, 32'h0000_0055);
			wr(`SADC_CTRL_ADDR, 32'h0000_0000);
			rd_chk(`SADC_CTRL_ADDR, 32'h80 | ch);
			rd_chk(`SADC_RES_ADDR, 32'h100 | ain[ch]);
		end
		wr(`SADC_CTRL_ADDR, 32'h0000_008E);
		t0 = cyc;
		wait_irq();
		chk_rng("rc cycles", 3 + 108 * 8, 4 + 112 * 8, cyc - t0);
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0096);
		rd_chk(`SADC_RES_ADDR, 32'h100 | ain[2]);
		wr(`SADC_CTRL_ADDR, 32'h0000_0082);
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0086);
		wr(`SADC_CTRL_ADDR, 32'h0000_0080);
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0080);
		wr(`SADC_CTRL_ADDR, 32'h0000_0089);
		repeat (5) @(posedge aclk);
		power_down <= 1'b1;
		repeat (40) @(posedge aclk);
		chk("irq after abort", 32'h0, {31'h0, conversion_irq});
		rd_chk(`SADC_CTRL_ADDR, 32'h0000_0081);
		rd(`SADC_RES_ADDR, rd_data);
		chk("result valid", 32'h0, rd_data & 32'h100);
		power_down <= 1'b0;
		close_out();
	end
endmodule
